// ==== branch_jump_defines.svh ====
`ifndef BRANCH_JUMP_DEFINES_SVH
`define BRANCH_JUMP_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL      8'h00
`define OFS_INSTR     8'h04
`define OFS_PC        8'h08
`define OFS_FLAGS     8'h0c
`define OFS_COUNT     8'h10
`define OFS_PTR       8'h14
`define OFS_IDX1      8'h18
`define OFS_IDX2      8'h1c
`define OFS_STATUS    8'h20
`define OFS_NEXT_PC   8'h24

// ****************************************
// Field positions
// ****************************************
`define CTRL_START_BIT   0
`define FLAG_CARRY_BIT   0
`define FLAG_ZERO_BIT    1
`define INSTR_PREFIX_LSB 0
`define INSTR_OPCODE_LSB 8
`define INSTR_DISP_LSB   16
`define ST_BUSY_BIT      0
`define ST_DONE_BIT      1
`define ST_TAKEN_BIT     2
`define ST_ILLEGAL_BIT   3
`define ST_MCNT_LSB      8
`define ST_MIDX_LSB      12
`define ST_TTOT_LSB      16

// ****************************************
// Opcodes and prefixes
// ****************************************
`define OP_REL_NO_CARRY  8'h30
`define OP_REL_ZERO      8'h28
`define OP_REL_NOT_NULL  8'h20
`define OP_LOOP_BRANCH   8'h10
`define OP_IND_JUMP      8'he9
`define PFX_NONE         8'h00
`define PFX_IDX1         8'hdd
`define PFX_IDX2         8'hfd

// ****************************************
// Timing in clock states, one clock each, and relative step
// ****************************************
`define T_FETCH      4'h4
`define T_FETCH_LOOP 4'h5
`define T_READ       4'h3
`define T_ADD        4'h5
`define T_IDX_FETCH  4'h4
`define REL_STEP     16'h0002

// ****************************************
// Reset values and bus answers
// ****************************************
`define RST_WORD16   16'h0000
`define RST_BYTE     8'h00
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10

`endif

// ==== branch_jump_pkg.sv ====
package branch_jump_pkg;
  // Execution sequencer states
  typedef enum logic [0:0] {ST_IDLE, ST_RUN} exec_state_e;
  // Sixteen-bit address word
  typedef logic [15:0] word16_t;
  // Clock states of up to three machine cycles
  typedef logic [2:0][3:0] tlen_t;
endpackage : branch_jump_pkg

// ==== jump_dec_if.sv ====
`timescale 1ns/1ps
interface jump_dec_if;
  import branch_jump_pkg::*;
  logic [7:0]  prefix;     // Prefix byte, zero if none
  logic [7:0]  opcode;     // Opcode byte
  logic [7:0]  disp;       // Displacement byte
  word16_t     pc;         // Opcode address
  word16_t     ptr;        // Memory pointer pair
  word16_t     idx1;       // First index register
  word16_t     idx2;       // Second index register
  logic [7:0]  count;      // Loop count before execution
  logic        carry;      // Carry flag
  logic        zero;       // Zero flag
  logic        known;      // Instruction handled here
  logic        taken;      // Flow changes
  word16_t     next_pc;    // Counter after execution
  logic [7:0]  count_next; // Loop count after execution
  logic [1:0]  m_cnt;      // Machine cycles used
  tlen_t       t_len;      // Clock states per machine cycle
  logic [4:0]  t_total;    // Clock states in all
  // Core side drives operands
  modport core (output prefix, opcode, disp, pc, ptr, idx1, idx2, count, carry, zero,
                input known, taken, next_pc, count_next, m_cnt, t_len, t_total);
  // Decoder side returns results
  modport dec (input prefix, opcode, disp, pc, ptr, idx1, idx2, count, carry, zero,
               output known, taken, next_pc, count_next, m_cnt, t_len, t_total);
endinterface : jump_dec_if

// ==== jump_decoder.sv ====
`timescale 1ns/1ps
`include "branch_jump_defines.svh"
module jump_decoder
  import branch_jump_pkg::*;
(
  // Operands in, results out
  jump_dec_if.dec bus
);
  word16_t disp_ext;  // Signed displacement
  word16_t rel_tgt;   // Relative target
  word16_t seq_pc;    // Address after two-byte form
  logic    cond;      // Condition met

  // ****************************************
  // Address arithmetic
  // ****************************************
  // sign extend, wrap
  assign disp_ext = {{8{bus.disp[7]}}, bus.disp};
  assign rel_tgt  = bus.pc + `REL_STEP + disp_ext;
  assign seq_pc   = bus.pc + `REL_STEP;

  // ****************************************
  // Decode and evaluate
  // ****************************************
  // Result per opcode; flags are never outputs
  always_comb begin
    bus.known      = 1'b1;
    bus.count_next = bus.count;
    bus.next_pc    = bus.pc;
    bus.t_len      = '0;
    cond           = 1'b0;
    bus.t_len[0]   = `T_FETCH;
    bus.t_len[1]   = `T_READ;
    bus.t_len[2]   = `T_ADD;
    if (bus.prefix == `PFX_NONE) begin
      case (bus.opcode)
        `OP_REL_NO_CARRY: cond = !bus.carry;
        `OP_REL_ZERO:     cond = bus.zero;
        `OP_REL_NOT_NULL: cond = !bus.zero;
        `OP_LOOP_BRANCH: begin
          bus.count_next = bus.count - 8'h01;
          cond           = (bus.count_next != `RST_BYTE);
          bus.t_len[0]   = `T_FETCH_LOOP;
        end
        `OP_IND_JUMP: begin
          cond         = 1'b1;
          bus.t_len[1] = 4'h0;
          bus.t_len[2] = 4'h0;
        end
        // Anything else is not this block's
        default: bus.known = 1'b0;
      endcase
    end else if (bus.opcode == `OP_IND_JUMP &&
                 (bus.prefix == `PFX_IDX1 || bus.prefix == `PFX_IDX2)) begin
      cond         = 1'b1;
      bus.t_len[0] = `T_IDX_FETCH;
      bus.t_len[1] = `T_IDX_FETCH;
      bus.t_len[2] = 4'h0;
    end else begin
      // Unknown prefix pairing
      bus.known = 1'b0;
    end
    // Target selection
    if (!bus.known) begin
      bus.next_pc = bus.pc;
      bus.t_len   = '0;
    end else if (bus.opcode == `OP_IND_JUMP) begin
      if (bus.prefix == `PFX_IDX1) begin
        bus.next_pc = bus.idx1;
      end else if (bus.prefix == `PFX_IDX2) begin
        bus.next_pc = bus.idx2;
      end else begin
        bus.next_pc = bus.ptr;
      end
    end else if (cond) begin
      bus.next_pc = rel_tgt;
    end else begin
      bus.next_pc  = seq_pc;
      bus.t_len[2] = 4'h0;
    end
    bus.taken = bus.known && cond;
  end

  // Machine cycle count from nonzero lengths
  assign bus.m_cnt   = 2'((bus.t_len[0] != 4'h0) + (bus.t_len[1] != 4'h0) + (bus.t_len[2] != 4'h0));
  assign bus.t_total = 5'(bus.t_len[0] + bus.t_len[1] + bus.t_len[2]);
endmodule : jump_decoder

// ==== branch_jump_unit.sv ====
`timescale 1ns/1ps
`include "branch_jump_defines.svh"
module branch_jump_unit
  import branch_jump_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Write address channel
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  // Write data channel
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  // Write response channel
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // Read address channel
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  // Read data channel
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Core view
  output      logic [15:0]       program_counter,
  output      logic              busy
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // Offsets need eight address bits
  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  // ****************************************
  // Declarations
  // ****************************************
  exec_state_e       state_q;       // Sequencer state
  logic              aw_q;          // Write address held
  logic [ADDR_W-1:0] awaddr_q;      // Held write address
  logic              w_q;           // Write data held
  logic [31:0]       wdata_q;       // Held write data
  logic [3:0]        wstrb_q;       // Held byte enables
  logic              bvalid_q;      // Write answer pending
  logic [1:0]        bresp_q;       // Write answer code
  logic              rvalid_q;      // Read answer pending
  logic [1:0]        rresp_q;       // Read answer code
  logic [31:0]       rdata_q;       // Read answer data
  logic              wr_fire;       // Write commits now
  logic              wr_map;        // Write address mapped
  logic [31:0]       wmerged;       // Data after byte enables
  logic [31:0]       rd_d;          // Read mux
  logic              rd_map;        // Read address mapped
  logic              start;         // Execution begins
  logic              finish;        // Last clock state
  logic [23:0]       instr_q;       // Prefix, opcode, displacement
  word16_t           pc_q;          // Program counter
  logic              carry_q;       // Carry flag
  logic              zero_q;        // Zero flag
  logic [7:0]        count_q;       // Loop count register
  word16_t           ptr_q;         // Memory pointer pair
  word16_t           idx1_q;        // First index register
  word16_t           idx2_q;        // Second index register
  logic              done_q;        // Sticky completion
  logic              taken_q;       // Last result branched
  logic              illegal_q;     // Last opcode unknown
  word16_t           res_pc_q;      // Latched next counter
  logic [7:0]        res_count_q;   // Latched next count
  logic [1:0]        m_cnt_q;       // Latched machine cycles
  tlen_t             t_len_q;       // Latched clock states
  logic [4:0]        t_tot_q;       // Latched total states
  logic [1:0]        m_idx_q;       // Current machine cycle
  logic [3:0]        t_cnt_q;       // Clock state in cycle

  jump_dec_if u_dec_if ();

  // ****************************************
  // Decoder
  // ****************************************
  assign u_dec_if.prefix = instr_q[`INSTR_PREFIX_LSB +: 8];
  assign u_dec_if.opcode = instr_q[`INSTR_OPCODE_LSB +: 8];
  assign u_dec_if.disp   = instr_q[`INSTR_DISP_LSB +: 8];
  assign u_dec_if.pc     = pc_q;
  assign u_dec_if.ptr    = ptr_q;
  assign u_dec_if.idx1   = idx1_q;
  assign u_dec_if.idx2   = idx2_q;
  assign u_dec_if.count  = count_q;
  assign u_dec_if.carry  = carry_q;
  assign u_dec_if.zero   = zero_q;

  jump_decoder u_dec (
    .bus (u_dec_if.dec)
  );

  // ****************************************
  // Write channels
  // ****************************************
  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_fire       = aw_q && w_q && !bvalid_q;
  assign busy          = (state_q == ST_RUN);
  assign program_counter = pc_q;

  // Byte enables merged over a zero word
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmerged[i*8 +: 8] = wstrb_q[i] ? wdata_q[i*8 +: 8] : 8'h00;
    end
  end

  // Address decode for writes
  always_comb begin
    if (awaddr_q == ADDR_W'(`OFS_CTRL) || awaddr_q == ADDR_W'(`OFS_INSTR)) begin
      wr_map = 1'b1;
    end else if (awaddr_q == ADDR_W'(`OFS_PC) || awaddr_q == ADDR_W'(`OFS_FLAGS)) begin
      wr_map = 1'b1;
    end else if (awaddr_q == ADDR_W'(`OFS_COUNT) || awaddr_q == ADDR_W'(`OFS_PTR)) begin
      wr_map = 1'b1;
    end else if (awaddr_q == ADDR_W'(`OFS_IDX1) || awaddr_q == ADDR_W'(`OFS_IDX2)) begin
      wr_map = 1'b1;
    end else if (awaddr_q == ADDR_W'(`OFS_STATUS) || awaddr_q == ADDR_W'(`OFS_NEXT_PC)) begin
      wr_map = 1'b1;
    end else begin
      wr_map = 1'b0;
    end
  end

  // Address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      awaddr_q <= '0;
      w_q      <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else begin
      if (s_axi_awvalid && !aw_q) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_q <= 1'b0;
      end
    end
  end

  // Write answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // Operand registers
  // ****************************************
  // Operand writes ignored while running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_q <= '0;
      ptr_q   <= `RST_WORD16;
      idx1_q  <= `RST_WORD16;
      idx2_q  <= `RST_WORD16;
    end else if (wr_fire && !busy) begin
      if (awaddr_q == ADDR_W'(`OFS_INSTR)) begin
        instr_q <= wmerged[23:0];
      end else if (awaddr_q == ADDR_W'(`OFS_PTR)) begin
        ptr_q <= wmerged[15:0];
      end else if (awaddr_q == ADDR_W'(`OFS_IDX1)) begin
        idx1_q <= wmerged[15:0];
      end else if (awaddr_q == ADDR_W'(`OFS_IDX2)) begin
        idx2_q <= wmerged[15:0];
      end
    end
  end

  // Flags written by software only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carry_q <= 1'b0;
      zero_q  <= 1'b0;
    end else if (wr_fire && !busy && awaddr_q == ADDR_W'(`OFS_FLAGS)) begin
      carry_q <= wmerged[`FLAG_CARRY_BIT];
      zero_q  <= wmerged[`FLAG_ZERO_BIT];
    end
  end

  // Program counter: software load or commit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= `RST_WORD16;
    end else if (finish) begin
      pc_q <= res_pc_q;
    end else if (wr_fire && !busy && awaddr_q == ADDR_W'(`OFS_PC)) begin
      pc_q <= wmerged[15:0];
    end
  end

  // Loop count: software load or commit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= `RST_BYTE;
    end else if (finish) begin
      count_q <= res_count_q;
    end else if (wr_fire && !busy && awaddr_q == ADDR_W'(`OFS_COUNT)) begin
      count_q <= wmerged[7:0];
    end
  end

  // ****************************************
  // Execution sequencer
  // ****************************************
  // Start only from idle, for known and unknown opcodes alike
  assign start  = wr_fire && !busy && awaddr_q == ADDR_W'(`OFS_CTRL) && wmerged[`CTRL_START_BIT];
  assign finish = busy && (t_cnt_q == t_len_q[m_idx_q]) && (m_idx_q == m_cnt_q - 2'h1);

  // Result latch at start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_pc_q    <= `RST_WORD16;
      res_count_q <= `RST_BYTE;
      m_cnt_q     <= '0;
      t_len_q     <= '0;
      t_tot_q     <= '0;
      taken_q     <= 1'b0;
      illegal_q   <= 1'b0;
    end else if (start) begin
      res_pc_q    <= u_dec_if.next_pc;
      res_count_q <= u_dec_if.count_next;
      m_cnt_q     <= u_dec_if.m_cnt;
      t_len_q     <= u_dec_if.t_len;
      t_tot_q     <= u_dec_if.t_total;
      taken_q     <= u_dec_if.taken;
      illegal_q   <= !u_dec_if.known;
    end
  end

  // One clock per clock state, cycle by cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      m_idx_q <= '0;
      t_cnt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // Unknown opcodes finish at once
          if (start && u_dec_if.known) begin
            state_q <= ST_RUN;
            m_idx_q <= '0;
            t_cnt_q <= 4'h1;
          end
        end
        ST_RUN: begin
          if (finish) begin
            state_q <= ST_IDLE;
            m_idx_q <= '0;
            t_cnt_q <= '0;
          end else if (t_cnt_q == t_len_q[m_idx_q]) begin
            m_idx_q <= m_idx_q + 2'h1;
            t_cnt_q <= 4'h1;
          end else begin
            t_cnt_q <= t_cnt_q + 4'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Sticky completion, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
    end else if (finish || (start && !u_dec_if.known)) begin
      done_q <= 1'b1;
    end else if (start) begin
      done_q <= 1'b0;
    end
  end

  // ****************************************
  // Read channels
  // ****************************************
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // Read mux; unused bits read zero
  always_comb begin
    rd_d   = '0;
    rd_map = 1'b1;
    if (s_axi_araddr == ADDR_W'(`OFS_CTRL)) begin
      rd_d = '0;
    end else if (s_axi_araddr == ADDR_W'(`OFS_INSTR)) begin
      rd_d[23:0] = instr_q;
    end else if (s_axi_araddr == ADDR_W'(`OFS_PC)) begin
      rd_d[15:0] = pc_q;
    end else if (s_axi_araddr == ADDR_W'(`OFS_FLAGS)) begin
      rd_d[`FLAG_CARRY_BIT] = carry_q;
      rd_d[`FLAG_ZERO_BIT]  = zero_q;
    end else if (s_axi_araddr == ADDR_W'(`OFS_COUNT)) begin
      rd_d[7:0] = count_q;
    end else if (s_axi_araddr == ADDR_W'(`OFS_PTR)) begin
      rd_d[15:0] = ptr_q;
    end else if (s_axi_araddr == ADDR_W'(`OFS_IDX1)) begin
      rd_d[15:0] = idx1_q;
    end else if (s_axi_araddr == ADDR_W'(`OFS_IDX2)) begin
      rd_d[15:0] = idx2_q;
    end else if (s_axi_araddr == ADDR_W'(`OFS_STATUS)) begin
      rd_d[`ST_BUSY_BIT]          = busy;
      rd_d[`ST_DONE_BIT]          = done_q;
      rd_d[`ST_TAKEN_BIT]         = taken_q;
      rd_d[`ST_ILLEGAL_BIT]       = illegal_q;
      rd_d[`ST_MCNT_LSB +: 2]     = m_cnt_q;
      rd_d[`ST_MIDX_LSB +: 2]     = m_idx_q;
      rd_d[`ST_TTOT_LSB +: 5]     = t_tot_q;
    end else if (s_axi_araddr == ADDR_W'(`OFS_NEXT_PC)) begin
      rd_d[15:0] = res_pc_q;
    end else begin
      rd_map = 1'b0;
    end
  end

  // Read answer register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `RESP_OKAY;
      rdata_q  <= '0;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
      rdata_q  <= rd_d;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : branch_jump_unit

// ==== branch_jump_unit_assertions.sv ====
`timescale 1ns/1ps
module branch_jump_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // Core view
  input wire logic [15:0] program_counter,
  input wire logic        busy
);
  // Busy cycles seen so far
  logic [4:0] blen_q;
  // Count busy cycles, clear when idle
  always_ff @(posedge aclk) begin
    if (!aresetn || !busy) begin
      blen_q <= 5'h00;
    end else begin
      blen_q <= blen_q + 5'h01;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************
  // Checks
  // ****************
  state_total_a: assert property (
    $fell(busy) |-> blen_q inside {5'h04, 5'h07, 5'h08, 5'h0c, 5'h0d}) else $error("busy length illegal");
  busy_bound_a: assert property (
    busy |-> blen_q < 5'h0d) else $error("busy too long");
  pc_hold_a: assert property (
    busy && $past(busy) |-> $stable(program_counter)) else $error("pc moved mid instruction");
  pc_cause_a: assert property (
    $changed(program_counter) |-> $fell(busy) || $rose(s_axi_bvalid)) else $error("pc moved without cause");
  start_cause_a: assert property (
    $rose(busy) |-> $rose(s_axi_bvalid)) else $error("busy rose without a write");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
  read_block_a: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while pending");
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid |=> ##1 s_axi_bvalid)
    else $error("write not answered");
endmodule : branch_jump_checker

bind branch_jump_unit branch_jump_checker branch_jump_checker_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .program_counter, .busy);

// ==== tb_branch_jump_unit.sv ====
`timescale 1ns/1ps
`include "branch_jump_defines.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_branch_jump_unit;
  import branch_jump_pkg::*;
  // One table case: instruction word, operands, results
  typedef struct packed {
    logic [23:0] ins;
    word16_t     pc;
    logic [1:0]  fl;
    logic [7:0]  cnt;
    word16_t     npc;
    logic [7:0]  ncnt;
    logic [4:0]  t;
    logic        pk;
  } row_s;
  // Bus and core signals
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  word16_t     program_counter;
  int          error_cnt = 0, num_checks = 0, busy_cyc = 0, t;
  logic [1:0]  m;  // Expected machine cycles of a row
  // Cases: carry, zero, wrap, indirect, loop, unknown
  row_s rows [15] = '{
    '{24'hfa3000, 16'h0480, 2'h0, 8'h05, 16'h047c, 8'h05, 5'h0c, 1'h1},
    '{24'h053000, 16'h0480, 2'h1, 8'h05, 16'h0482, 8'h05, 5'h07, 1'h0},
    '{24'h032800, 16'h0300, 2'h2, 8'h05, 16'h0305, 8'h05, 5'h0c, 1'h0},
    '{24'h032800, 16'h0300, 2'h0, 8'h05, 16'h0302, 8'h05, 5'h07, 1'h0},
    '{24'hfa2000, 16'h0480, 2'h0, 8'h05, 16'h047c, 8'h05, 5'h0c, 1'h0},
    '{24'hfa2000, 16'h0480, 2'h2, 8'h05, 16'h0482, 8'h05, 5'h07, 1'h0},
    '{24'h7f2000, 16'hfff0, 2'h1, 8'h05, 16'h0071, 8'h05, 5'h0c, 1'h0},
    '{24'h802800, 16'h0010, 2'h3, 8'h05, 16'hff92, 8'h05, 5'h0c, 1'h0},
    '{24'h00e900, 16'h1000, 2'h0, 8'h05, 16'h4800, 8'h05, 5'h04, 1'h0},
    '{24'h00e9dd, 16'h1000, 2'h0, 8'h05, 16'h1234, 8'h05, 5'h08, 1'h0},
    '{24'h00e9fd, 16'h1000, 2'h0, 8'h05, 16'hbeef, 8'h05, 5'h08, 1'h0},
    '{24'hfe1000, 16'h0200, 2'h3, 8'h03, 16'h0200, 8'h02, 5'h0d, 1'h0},
    '{24'hfe1000, 16'h0200, 2'h0, 8'h01, 16'h0202, 8'h00, 5'h08, 1'h0},
    '{24'h051000, 16'h0200, 2'h0, 8'h00, 16'h0207, 8'hff, 5'h0d, 1'h0},
    '{24'h001800, 16'h0700, 2'h0, 8'h05, 16'h0700, 8'h05, 5'h00, 1'h0}};
  branch_jump_unit branch_jump_unit_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .program_counter, .busy);
  // ****************
  // Clock and counting
  // ****************
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  // Busy cycles sampled at each rising edge
  always @(posedge aclk) begin
    if (busy === 1'h1) busy_cyc <= busy_cyc + 1;
  end
  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // Bus write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic at, wt, bt;
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      at = s_axi_awvalid && s_axi_awready;
      wt = s_axi_wvalid && s_axi_wready;
      bt = s_axi_bvalid && s_axi_bready;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (at) s_axi_awvalid <= 1'h0;
      if (wt) s_axi_wvalid <= 1'h0;
      if (bt) begin
        s_axi_bready <= 1'h0;
        break;
      end
    end
    if (n == 50) begin
      error_cnt++;
      summarize();
    end
  endtask : wr
  // Bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic at, rt;
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      at = s_axi_arvalid && s_axi_arready;
      rt = s_axi_rvalid && s_axi_rready;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (at) s_axi_arvalid <= 1'h0;
      if (rt) begin
        s_axi_rready <= 1'h0;
        break;
      end
    end
    if (n == 50) begin
      error_cnt++;
      summarize();
    end
  endtask : rd
  // Load operands, start, count busy cycles
  task automatic run(input row_s x, output int tc);
    int b0, n;
    wr(`OFS_PC, {16'h0, x.pc}, r);
    wr(`OFS_FLAGS, {30'h0, x.fl}, r);
    wr(`OFS_COUNT, {24'h0, x.cnt}, r);
    wr(`OFS_INSTR, {8'h0, x.ins}, r);
    b0 = busy_cyc;
    wr(`OFS_CTRL, 32'h1, r);
    // Write while busy is ignored
    if (x.pk) wr(`OFS_PC, 32'h5555, r);
    for (n = 0; n < 40 && busy !== 1'h0; n++) @(negedge aclk);
    tc = busy_cyc - b0;
    @(posedge aclk);
    if (n == 40) begin
      error_cnt++;
      summarize();
    end
  endtask : run
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`OFS_PC, d, r);
    `CHK("pc reset", 32'h0, d)
    wr(`OFS_PTR, 32'h4800, r);
    wr(`OFS_IDX1, 32'h1234, r);
    wr(`OFS_IDX2, 32'hbeef, r);
    foreach (rows[i]) begin
      run(rows[i], t);
      `CHK("states", rows[i].t, t[4:0])
      `CHK("pc", rows[i].npc, program_counter)
      rd(`OFS_COUNT, d, r);
      `CHK("count", {24'h0, rows[i].ncnt}, d)
      rd(`OFS_FLAGS, d, r);
      `CHK("flags", {30'h0, rows[i].fl}, d)
      rd(`OFS_STATUS, d, r);
      `CHK("rresp", `RESP_OKAY, r)
      `CHK("total states", rows[i].t, d[`ST_TTOT_LSB +: 5])
      m = (rows[i].t == 5'h00) ? 2'h0 : (rows[i].t == 5'h04) ? 2'h1 : (rows[i].t > 5'h09) ? 2'h3 : 2'h2;
      `CHK("m cycles", m, d[`ST_MCNT_LSB +: 2])
      `CHK("taken", rows[i].t > 5'h09 || rows[i].ins[15:8] == `OP_IND_JUMP, d[`ST_TAKEN_BIT])
    end
    rd(`OFS_STATUS, d, r);
    `CHK("unknown op", 3'h5, d[3:1])
    wr(8'h28, 32'h1, r);
    `CHK("wr unmapped", `RESP_SLVERR, r)
    rd(8'h28, d, r);
    `CHK("rd unmapped", `RESP_SLVERR, r)
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    `CHK("pc rerun", 16'h0000, program_counter)
    `CHK("bus idle", 6'h38, {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, busy})
    rd(`OFS_COUNT, d, r);
    `CHK("count rerun", 32'h0, d)
    `CHK("rresp rerun", `RESP_OKAY, r)
    summarize();
  end
endmodule : tb_branch_jump_unit
